// ### three_wire_register_port_bench.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench of the three-wire register port
module three_wire_register_port_bench
    import twrp_pkg::*;
;

    logic        clk_in     = 1'b0; // System clock
    logic        sys_rst_in = 1'b1; // Reset
    logic        event_drv  = 1'b0; // Tuner event
    logic        strobe;            // Host strobe
    logic        select;            // Host select
    logic        line;              // Data line level
    logic        data_out;          // Device data level
    logic        data_oe;           // Device drives line
    logic        reg_wr;            // Write pulse to core
    logic [7:0]  wr_block;          // Block of write
    logic [7:0]  wr_addr;           // Address of write
    logic [7:0]  wr_data;           // Data of write
    logic [7:0]  rd_block;          // Selected block
    logic [7:0]  rd_addr;           // Read address
    logic [7:0]  rd_data;           // Core read answer
    logic        armed;             // Interrupt armed
    logic        sel_q = 1'b0;      // Select of last cycle
    logic [23:0] wr_seen = 24'h0;   // Fields of last write
    logic [7:0]  v;                 // Value read back
    int          fails = 0;         // Mismatches
    int          checks_done = 0;   // Comparisons
    int          wr_cnt = 0;        // Write pulses seen
    int          same_cnt = 0;      // Cycles select unchanged

    // Clock
    always #50 clk_in = ~clk_in;

    // Core register file stand-in
    function automatic logic [7:0] core_val(input logic [7:0] blk, input logic [7:0] addr);
        return addr ^ {blk[3:0], 4'h9};
    endfunction : core_val
    assign rd_data = core_val(rd_block, rd_addr);

    // Design under test
    twrp_top u_twrp_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .strobe_clk_in(strobe),
        .write_read_select_in(select), .data_in(line), .data_out_out(data_out),
        .data_oe_out(data_oe), .reg_wr_out(reg_wr), .reg_wr_block_out(wr_block),
        .reg_wr_addr_out(wr_addr), .reg_wr_data_out(wr_data), .reg_rd_block_out(rd_block),
        .reg_rd_addr_out(rd_addr), .reg_rd_data_in(rd_data), .event_in(event_drv),
        .irq_armed_out(armed));

    // Host on the far side
    twrp_host_model u_twrp_host_model (.dev_data_in(data_out), .dev_oe_in(data_oe),
        .strobe_out(strobe), .select_out(select), .line_out(line));

    // Compare and count
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Verdict and end of run
    task automatic summarize;
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    // Capture every write pulse in the settled half cycle
    always @(negedge clk_in)
    begin
        if (reg_wr === 1'b1)
        begin
            wr_cnt++;
            wr_seen = {wr_block, wr_addr, wr_data};
        end
    end

    // Line driver must follow the settled select level
    always @(negedge clk_in)
    begin
        same_cnt = (select === sel_q) ? same_cnt + 1 : 0;
        sel_q = select;
        if (sys_rst_in === 1'b0 && same_cnt > 5)
            chk("data_oe", {23'h0, ~select}, {23'h0, data_oe});
    end

    // Hang guard
    initial
    begin
        #3000000 fails++;
        summarize();
    end

    // One write frame expected to reach the core exactly once
    task automatic write_check(input logic [7:0] addr, input logic [7:0] data,
                               input logic [7:0] blk);
        int n;
        n = wr_cnt;
        u_twrp_host_model.write({addr, data});
        chk("wr_count", 24'(n + 1), 24'(wr_cnt));
        chk("wr_fields", {blk, addr, data}, wr_seen);
    endtask : write_check

    // Event pulse, then look at the idle line level
    task automatic event_check(input logic exp);
        @(posedge clk_in) #2 event_drv = 1'b1;
        @(posedge clk_in) #2 event_drv = 1'b0;
        repeat (3) @(posedge clk_in);
        #2 chk("idle_level", {23'h0, exp}, {23'h0, data_out});
    endtask : event_check

    // Values held during reset
    task automatic sc_reset;
        chk("rst_outs", {21'h0, 3'b110}, {21'h0, data_oe, data_out, reg_wr});
        chk("rst_block", {16'h0, BLOCK_RST}, {16'h0, rd_block});
        chk("rst_armed", 24'h0, {23'h0, armed});
    endtask : sc_reset

    // Back-to-back writes, asymmetric bit patterns
    task automatic sc_write;
        write_check(8'h23, 8'h5C, BLOCK_RST);
        write_check(8'hC4, 8'hA1, BLOCK_RST);
    endtask : sc_write

    // Block select is kept and not passed on
    task automatic sc_block;
        int n;
        n = wr_cnt;
        u_twrp_host_model.write({BLOCK_SELECT_ADDR, 8'h03});
        chk("blk_no_wr", 24'(n), 24'(wr_cnt));
        chk("block_select", 24'h03, {16'h0, rd_block});
        write_check(8'h11, 8'h7E, 8'h03);
    endtask : sc_block

    // Reads from the kept block, line idles afterwards
    task automatic sc_read;
        u_twrp_host_model.read(8'h46, 8, v);
        chk("rd_val", {16'h0, core_val(8'h03, 8'h46)}, {16'h0, v});
        u_twrp_host_model.read(8'hB9, 8, v);
        chk("rd_val2", {16'h0, core_val(8'h03, 8'hB9)}, {16'h0, v});
        chk("rd_idle", {23'h0, ~IRQ_ACTIVE}, {23'h0, data_out});
    endtask : sc_read

    // Frames of a wrong length are ignored
    task automatic sc_refuse;
        int n;
        n = wr_cnt;
        u_twrp_host_model.shift(16'h0ABC, 12);
        #700 chk("odd_no_wr", 24'(n), 24'(wr_cnt));
        u_twrp_host_model.read(8'h46, 12, v);
        chk("odd_no_rd", 24'hFF, {16'h0, v});
    endtask : sc_refuse

    // Interrupt on the idle data line, armed and re-armed by a write
    task automatic sc_irq;
        event_check(~IRQ_ACTIVE);
        u_twrp_host_model.write({BLOCK_SELECT_ADDR, IRQ_ARM_BLK});
        u_twrp_host_model.write({IRQ_ARM_ADDR, 8'h5A});
        chk("armed", 24'h1, {23'h0, armed});
        event_check(IRQ_ACTIVE);
        chk("host_line", {23'h0, IRQ_ACTIVE}, {23'h0, line});
        u_twrp_host_model.write({IRQ_ARM_ADDR, 8'hA5});
        chk("rearm_clr", {23'h0, ~IRQ_ACTIVE}, {23'h0, data_out});
    endtask : sc_irq

    // Main sequence
    initial
    begin
        repeat (2) @(posedge clk_in);
        #2 sc_reset();
        repeat (2) @(posedge clk_in);
        #2 sys_rst_in = 1'b0;
        repeat (3) @(posedge clk_in);
        #2 sc_write();
        sc_block();
        sc_read();
        sc_refuse();
        sc_irq();
        summarize();
    end
endmodule : three_wire_register_port_bench
`default_nettype wire

// ### twrp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host model: three general purpose pins, strobe standing still between frames
module twrp_host_model
(
    // Device side of the data line
    input  wire logic dev_data_in,
    input  wire logic dev_oe_in,
    // Host pins
    output logic      strobe_out,
    output logic      select_out,
    output logic      line_out
);
    logic host_d;           // Host data level
    logic host_oe;          // Host drives the line
    logic flip = 1'b0;      // Undriven line pattern

    // Undriven line keeps changing so a stale level is never read
    always #20 flip = ~flip;
    // Wire level from both drivers
    assign line_out = host_oe ? host_d : (dev_oe_in ? dev_data_in : flip);

    // Power-up idle in read mode
    initial
    begin
        host_oe    = 1'b0;
        host_d     = 1'b0;
        select_out = 1'b0;
        strobe_out = 1'b1;
    end

    // Shift nbits, first bit first, then go back to read mode
    task automatic shift(input logic [15:0] value, input int nbits);
        select_out = 1'b1;
        // Wait until the device has surely let go of the line
        #760 host_oe = 1'b1;
        for (int i = 0; i < nbits; i++)
        begin
            #40 strobe_out = 1'b0;
            host_d = value[i];
            #40 strobe_out = 1'b1;
        end
        #40 host_oe = 1'b0;
        #40 select_out = 1'b0;
    endtask : shift

    // Whole write frame with spacing before the next one
    task automatic write(input logic [15:0] value);
        shift(value, 16);
        #700;
    endtask : write

    // Address phase, fetch wait, eight bits and one closing fall
    task automatic read(input logic [7:0] addr, input int nbits, output logic [7:0] value);
        shift({8'h00, addr}, nbits);
        #600;
        for (int i = 0; i < 9; i++)
        begin
            #40 strobe_out = 1'b0;
            #40 strobe_out = 1'b1;
            if (i < 8)
                value[i] = line_out;
        end
        #700;
    endtask : read
endmodule : twrp_host_model
`default_nettype wire

// ### twrp_link.sv
`timescale 1ns/100ps
`default_nettype none
// Logic clocked by the host strobe: shifts frames in and read bits out
module twrp_link
    import twrp_pkg::*;
(
    // Link clock and reset
    input  wire logic   strobe_clk_in,
    input  wire logic   sys_rst_in,
    // Pins
    input  wire logic   write_read_select_in,
    input  wire logic   data_in,
    // Carrier to the system side
    twrp_link_if.link   lnk
);

    twrp_lnk_s s, next_s;                            // Rising edge state
    twrp_rd_s  r, next_r;                            // Falling edge state
    logic      in_frame;                             // A write frame has begun
    logic      wr_clr;                               // Ends the write frame
    logic      rd_clr;                               // Ends the read phase

    // Frames end on the select line itself, the strobe is idle then
    assign wr_clr = sys_rst_in | ~write_read_select_in;
    assign rd_clr = sys_rst_in | write_read_select_in;

    // Marks that the current frame has taken its first bit
    always_ff @(posedge strobe_clk_in or posedge wr_clr)
    begin
        if (wr_clr)
            in_frame <= 1'b0;
        else
            in_frame <= 1'b1;
    end

    // Shift in on the rising edge, first bit ends up at bit 0
    always_comb
    begin
        next_s = s;
        if (write_read_select_in)
        begin
            next_s.word = {data_in, s.word[15:1]};
            if (!in_frame)
                next_s.cnt = 5'h01;
            else if (s.cnt != CNT_MAX)
                next_s.cnt = s.cnt + 5'h01;
        end
    end

    // Rising edge register
    always_ff @(posedge strobe_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            s <= '0;
        else
            s <= next_s;
    end

    // Drive read bits on the falling edge after an address frame
    always_comb
    begin
        next_r = r;
        if (s.cnt == RD_BITS)
        begin
            if (!r.drive && r.idx == 4'h0)
            begin
                next_r.bit_q = lnk.rd_byte[0];
                next_r.drive = 1'b1;
                next_r.idx   = 4'h1;
            end
            else if (r.idx <= RD_LAST)
            begin
                next_r.bit_q = lnk.rd_byte[r.idx[2:0]];
                next_r.idx   = r.idx + 4'h1;
            end
            else
                next_r.drive = 1'b0;
        end
    end

    // Falling edge register, cleared while the host writes
    always_ff @(negedge strobe_clk_in or posedge rd_clr)
    begin
        if (rd_clr)
            r <= '0;
        else
            r <= next_r;
    end

    // Carrier outputs
    assign lnk.word   = s.word;
    assign lnk.cnt    = s.cnt;
    assign lnk.drive  = r.drive;
    assign lnk.rd_bit = r.bit_q;

    // Count steps by one inside a frame
    a_cnt_step: assert property (@(posedge strobe_clk_in) disable iff (sys_rst_in)
        write_read_select_in && in_frame && s.cnt < WR_BITS |=> s.cnt == $past(s.cnt) + 5'h01)
        else $error("frame bit count did not step");

    // First read bit is bit 0 of the read value
    a_rd_first: assert property (@(negedge strobe_clk_in) disable iff (rd_clr)
        !r.drive && r.idx == 4'h0 && s.cnt == RD_BITS |=> r.drive && r.bit_q == lnk.rd_byte[0])
        else $error("read did not start with bit 0");

    // Exactly eight bits are driven, seen at the host's sampling edge
    a_rd_eight: assert property (@(posedge strobe_clk_in) disable iff (rd_clr)
        $rose(r.drive) |-> r.drive [*8] ##1 !r.drive)
        else $error("read did not last eight bits");

endmodule : twrp_link
`default_nettype wire

// ### twrp_link_if.sv
`timescale 1ns/100ps
`default_nettype none
// Carrier between the link side and the system side
interface twrp_link_if;
    logic [15:0] word;                               // Frame bits, stable after select falls
    logic [4:0]  cnt;                                // Bits taken in the last frame
    logic [7:0]  rd_byte;                            // Read value, stable before first bit
    logic        drive;                              // Read bit is valid
    logic        rd_bit;                             // Read bit

    // Link clock side
    modport link
    (
        output word,
        output cnt,
        output drive,
        output rd_bit,
        input  rd_byte
    );

    // System clock side
    modport core
    (
        input  word,
        input  cnt,
        input  drive,
        input  rd_bit,
        output rd_byte
    );
endinterface : twrp_link_if
`default_nettype wire

// ### twrp_pkg.sv
// Shared constants and state types of the three-wire register port
package twrp_pkg;

    // Frame geometry
    localparam int         FRAME_W      = 16;        // Bits of a write frame
    localparam int         BYTE_W       = 8;         // Bits of address or data
    localparam logic [4:0] WR_BITS      = 5'h10;     // Bit count of a write frame
    localparam logic [4:0] RD_BITS      = 5'h08;     // Bit count of a read address
    localparam logic [4:0] CNT_MAX      = 5'h1F;     // Bit counter saturates here
    localparam logic [3:0] RD_LAST      = 4'h7;      // Index of last read bit

    // Register map
    localparam logic [7:0] BLOCK_SELECT_ADDR = 8'h01;     // Block select offset
    localparam logic [7:0] BLOCK_RST    = 8'h00;     // Block number after reset
    localparam logic [7:0] IRQ_ARM_BLK  = 8'h01;     // Block of the interrupt arm register
    localparam logic [7:0] IRQ_ARM_ADDR = 8'h0F;     // Offset of the interrupt arm register

    // Line levels
    localparam logic       IRQ_ACTIVE   = 1'b0;      // Data line level of a pending event
    localparam logic [2:0] SYNC_RST     = 3'h0;      // Synchroniser after reset

    // Settled level of the select line
    typedef enum logic
    {
        SEL_READ  = 1'b0,                            // Device may drive the data line
        SEL_WRITE = 1'b1                             // Host drives the data line
    } twrp_sel_e;

    // System clock state
    typedef struct packed
    {
        logic [2:0] sync;                            // Select line synchroniser
        twrp_sel_e  sel;                             // Settled select level
        logic [7:0] block;                           // Selected register block
        logic [7:0] rd_addr;                         // Address offered to the core
        logic [7:0] rd_byte;                         // Byte handed to the link side
        logic       wr;                              // Register write strobe
        logic [7:0] wr_block;                        // Block of the write
        logic [7:0] wr_addr;                         // Address of the write
        logic [7:0] wr_data;                         // Data of the write
        logic       armed;                           // Interrupt output armed
        logic       pend;                            // Event seen while armed
        logic       irq;                             // Data line level when idle
        logic       oe;                              // Data line driven by device
    } twrp_sys_s;

    // Link clock state, rising edge
    typedef struct packed
    {
        logic [15:0] word;                           // Shifted frame, first bit at 0
        logic [4:0]  cnt;                            // Bits taken in this frame
    } twrp_lnk_s;

    // Link clock state, falling edge
    typedef struct packed
    {
        logic [3:0] idx;                             // Index of the next bit to drive
        logic       bit_q;                           // Bit on the data line
        logic       drive;                           // Read data is on the line
    } twrp_rd_s;

endpackage : twrp_pkg

// ### twrp_top.sv
`timescale 1ns/100ps
`default_nettype none
module twrp_top
    import twrp_pkg::*;
(
    // System clock and reset
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    // Three-wire pins
    input  wire logic       strobe_clk_in,
    input  wire logic       write_read_select_in,
    input  wire logic       data_in,
    output logic            data_out_out,
    output logic            data_oe_out,
    // Register write port to the tuner core
    output logic            reg_wr_out,
    output logic [7:0]      reg_wr_block_out,
    output logic [7:0]      reg_wr_addr_out,
    output logic [7:0]      reg_wr_data_out,
    // Register read port to the tuner core
    output logic [7:0]      reg_rd_block_out,
    output logic [7:0]      reg_rd_addr_out,
    input  wire logic [7:0] reg_rd_data_in,
    // Tuner events
    input  wire logic       event_in,
    output logic            irq_armed_out
);

    twrp_sys_s   s;                                  // Registered state
    twrp_sys_s   next_s;                             // Next state
    twrp_link_if lnk ();                             // Carrier to the link side
    logic        sel_settled;                        // Second and third stages agree
    logic        sel_fall;                           // Select settled low after a frame
    logic        wr_frame;                           // Frame was a register write
    logic        rd_frame;                           // Frame was a read address
    logic        arm_hit;                            // Write aimed at the arm register

    // Link side logic on the host strobe
    twrp_link u_link
    (
        .strobe_clk_in        (strobe_clk_in),
        .sys_rst_in           (sys_rst_in),
        .write_read_select_in (write_read_select_in),
        .data_in              (data_in),
        .lnk                  (lnk.link)
    );

    // Select edge detection on the settled stages only
    assign sel_settled = (s.sync[2] == s.sync[1]);
    assign sel_fall    = sel_settled && (s.sync[2] == SEL_READ) && (s.sel == SEL_WRITE);

    // Frame kind by the bit count the link side took
    assign wr_frame = sel_fall && (lnk.cnt == WR_BITS);
    assign rd_frame = sel_fall && (lnk.cnt == RD_BITS);

    // Arm register write in its own block
    assign arm_hit = wr_frame && (lnk.word[15:8] == IRQ_ARM_ADDR) && (s.block == IRQ_ARM_BLK);

    // Next state
    always_comb
    begin
        next_s    = s;
        next_s.wr = 1'b0;
        // Three stage synchroniser of the select pin
        next_s.sync = {s.sync[1:0], write_read_select_in};
        // Settled select level
        if (sel_settled)
            next_s.sel = twrp_sel_e'(s.sync[2]);
        // Address offered to the core, stable long before the settled fall
        next_s.rd_addr = lnk.word[15:8];
        // Commit a write frame
        if (wr_frame)
        begin
            if (lnk.word[15:8] == BLOCK_SELECT_ADDR)
                next_s.block = lnk.word[7:0];
            else
            begin
                next_s.wr       = 1'b1;
                next_s.wr_block = s.block;
                next_s.wr_addr  = lnk.word[15:8];
                next_s.wr_data  = lnk.word[7:0];
            end
        end
        // Fetch the read value before the first falling strobe edge
        if (rd_frame)
            next_s.rd_byte = reg_rd_data_in;
        // Any write to the arm register arms and clears the pending event
        if (arm_hit)
        begin
            next_s.armed = 1'b1;
            next_s.pend  = 1'b0;
        end
        // An event in the same cycle as the rewrite still counts
        if (event_in && (s.armed || arm_hit))
            next_s.pend = 1'b1;
        // Idle level of the data line
        next_s.irq = (s.armed && s.pend) ? IRQ_ACTIVE : ~IRQ_ACTIVE;
        // Device drives only while the settled select is low
        next_s.oe = (next_s.sel == SEL_READ);
    end

    // State register
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            s       <= '0;
            s.sync  <= SYNC_RST;
            s.sel   <= SEL_READ;
            s.block <= BLOCK_RST;
            s.irq   <= ~IRQ_ACTIVE;
            s.oe    <= 1'b1;
        end
        else
            s <= next_s;
    end

    // Read value to the link side, quiet while bits shift out
    assign lnk.rd_byte = s.rd_byte;

    // Data line: read bits while shifting, otherwise the event level
    assign data_out_out = lnk.drive ? lnk.rd_bit : s.irq;
    assign data_oe_out  = s.oe;

    // Core ports
    assign reg_wr_out       = s.wr;
    assign reg_wr_block_out = s.wr_block;
    assign reg_wr_addr_out  = s.wr_addr;
    assign reg_wr_data_out  = s.wr_data;
    assign reg_rd_block_out = s.block;
    assign reg_rd_addr_out  = s.rd_addr;
    assign irq_armed_out    = s.armed;

    // Settled select follows agreeing stages
    a_sel_settle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        sel_settled |=> s.sel == $past(s.sync[2]))
        else $error("settled select did not follow synchroniser");

    // Output enable tracks the settled select
    a_oe_follow: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s.sel == SEL_WRITE |-> !data_oe_out)
        else $error("data line driven while host writes");

    // Block select write takes the low byte
    a_block_load: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_frame && lnk.word[15:8] == BLOCK_SELECT_ADDR |=> s.block == $past(lnk.word[7:0]) && !reg_wr_out)
        else $error("block select not taken");

    // Block holds without a block select write
    a_block_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !(wr_frame && lnk.word[15:8] == BLOCK_SELECT_ADDR) |=> $stable(s.block))
        else $error("block changed without block select");

    // Write frame reaches the core one cycle after the fall
    a_wr_commit: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_frame && lnk.word[15:8] != BLOCK_SELECT_ADDR
        |=> reg_wr_out && reg_wr_addr_out == $past(lnk.word[15:8])
            && reg_wr_data_out == $past(lnk.word[7:0]) ##1 !reg_wr_out)
        else $error("write frame not committed once");

    // Strobe only after a sixteen bit frame
    a_wr_length: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        reg_wr_out |-> $past(lnk.cnt) == WR_BITS && $past(sel_fall))
        else $error("write strobe without sixteen bit frame");

    // Read address frame loads the read value
    a_rd_fetch: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        rd_frame |=> s.rd_byte == $past(reg_rd_data_in) && !reg_wr_out)
        else $error("read value not fetched");

    // Arm write clears the pending event and arms
    a_arm_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        arm_hit && !event_in |=> irq_armed_out && !s.pend ##1 data_out_out == ~IRQ_ACTIVE || lnk.drive)
        else $error("arm write did not rearm");

    // Armed event reaches the idle data line in two cycles
    a_irq_line: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s.armed && event_in && !arm_hit |-> ##2 s.irq == IRQ_ACTIVE)
        else $error("event not shown on data line");

    // Device lets go of the line once the select settles high
    a_oe_release: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        sel_settled && s.sync[2] == SEL_WRITE |=> !data_oe_out)
        else $error("data line not released after select rose");

    // Device takes the line once the select settles low
    a_oe_take: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        sel_settled && s.sync[2] == SEL_READ |=> data_oe_out)
        else $error("data line not driven after select fell");

    // A register write carries the block kept from the last select
    a_wr_block: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_frame && lnk.word[15:8] != BLOCK_SELECT_ADDR |=> reg_wr_block_out == $past(s.block))
        else $error("write left the selected block");

    // A pending event stays until the arm register is rewritten
    a_pend_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s.pend && !arm_hit |=> s.pend)
        else $error("pending event lost without rewrite");

    // Without arming the idle line never shows an event
    a_unarmed_quiet: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !s.armed |=> s.irq == ~IRQ_ACTIVE)
        else $error("event shown while not armed");

endmodule : twrp_top
`default_nettype wire
